//--- hdl/eau_core.sv
// Purpose: Operand and effective address generation with base register update
// Assumes: Decoded request in, general registers held here, one memory read port
// Notes: Register write-back from execution wins over a base update on the same
// register in the same cycle
`timescale 1ns/1ps

// Function
// RULE1 - Register direct takes the operand from the selected 8- or 16-bit register
// RULE2 - Only eight named instructions may use word operands, all others bytes
// RULE3 - Register indirect uses the selected 16-bit register as address
// RULE4 - Displacement mode adds bytes 3-4 to the register; moves only
// RULE5 - Post-increment loads access first, then add 1 or 2 to register
// RULE6 - Pre-decrement stores subtract 1 or 2 first, use and keep result
// RULE7 - Software keeps word move addresses and base registers even
// RULE8 - Short absolute addresses get an all-ones upper byte
// RULE9 - Short absolute for byte moves and bits; long for moves and jumps
// RULE10 - Byte immediate from byte 2, word immediate from bytes 3-4, moves only
// RULE11 - Small add/subtract imply 1 or 2; bit number from byte 2 or 4
// RULE12 - Relative branches add sign-extended byte 2 to the program counter
// RULE13 - Software keeps branch targets in range and displacements even
// RULE14 - Memory indirect reads the target word from page zero address byte 2
// RULE15 - Odd branch targets and word move addresses lose their low bit
// RULE16 - Arithmetic and logic use register direct; seven also take immediates
// RULE17 - Transfers accept all modes except relative and memory indirect
// RULE18 - Bit operands by direct, indirect or short absolute; number as stated
// RULE19 - Push and pop are word moves with pre-decrement and post-increment on register 7
// RULE20 - Fifty-five instructions are recognised in eight groups
// RULE21 - Register 7 is the stack pointer used implicitly by subroutine calls
// RULE22 - Program counter low bit is ignored and taken as zero
// RULE23 - Address sums wrap within the 16-bit space
module eau_core import eau_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Decoded instruction request
  input wire logic req_valid_in,
  input wire eau_req_s req_in,
  // Register write-back from execution
  input wire logic gpr_wr_in,
  input wire logic [2:0] gpr_wr_idx_in,
  input wire logic [15:0] gpr_wr_data_in,
  // Data memory read port
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  // Result
  output logic busy_out,
  output logic res_valid_out,
  output logic res_err_out,
  output eau_res_s res_out,
  output logic [15:0] sp_out
);

  eau_state_e state_q;
  logic [15:0] gpr_q [EAU_NUM_GPR];
  logic take;
  logic legal;
  logic ok_take;
  eau_grp_e grp;
  logic [15:0] base;
  logic [15:0] step;
  logic [15:0] inc_val;
  logic [15:0] dec_val;
  logic [15:0] pc_even;
  logic [15:0] sp_val;
  logic [15:0] bit_src;
  logic upd_en_d;
  logic [2:0] upd_idx_d;
  logic [15:0] upd_val_d;
  logic fetch_d;
  eau_res_s res_d;

  eau_mode_check u_check (
    .req_in(req_in),
    .legal_out(legal),
    .grp_out(grp)
  );

  // A request is only looked at while no memory fetch is pending
  assign take = req_valid_in && state_q == EAU_ST_IDLE;
  assign ok_take = take && legal;
  assign sp_out = gpr_q[EAU_SP_IDX]; // RULE21

  always_comb begin
    base = gpr_q[req_in.reg_idx];
    sp_val = gpr_q[EAU_SP_IDX];
    bit_src = gpr_q[req_in.bit_ridx];
    step = req_in.word ? EAU_WORD_STEP : EAU_BYTE_STEP;
    inc_val = base + step; // RULE23
    dec_val = base - step; // RULE23
    pc_even = {req_in.pc[15:1], 1'b0}; // RULE22
    upd_en_d = 1'b0;
    upd_idx_d = req_in.reg_idx;
    upd_val_d = base;
    fetch_d = 1'b0;
    res_d = '0;
    res_d.insn = req_in.insn; // RULE20
    res_d.mode = req_in.mode;
    res_d.grp = grp; // RULE20
    res_d.word = req_in.word;
    case (req_in.mode)
      EAU_M_REG_DIRECT: begin
        if (req_in.word) begin
          res_d.operand = base; // RULE1
        end else if (req_in.reg_hi) begin
          res_d.operand = {8'h00, base[15:8]}; // RULE1
        end else begin
          res_d.operand = {8'h00, base[7:0]}; // RULE1
        end
      end
      EAU_M_REG_INDIRECT: begin
        res_d.ea = base; // RULE3
      end
      EAU_M_DISP16: begin
        res_d.ea = base + req_in.ext_word; // RULE4 RULE23
      end
      EAU_M_POST_INC: begin
        res_d.ea = base; // RULE5
        upd_en_d = 1'b1;
        upd_val_d = inc_val; // RULE5
      end
      EAU_M_PRE_DEC: begin
        res_d.ea = dec_val; // RULE6
        upd_en_d = 1'b1;
        upd_val_d = dec_val; // RULE6
      end
      EAU_M_ABS8: begin
        res_d.ea = {EAU_ABS8_PAGE, req_in.byte2}; // RULE8
      end
      EAU_M_ABS16: begin
        res_d.ea = req_in.ext_word;
      end
      EAU_M_IMM8: begin
        res_d.operand = {8'h00, req_in.byte2}; // RULE10
      end
      EAU_M_IMM16: begin
        res_d.operand = req_in.ext_word; // RULE10
      end
      EAU_M_PC_REL: begin
        res_d.target = pc_even + {{8{req_in.byte2[7]}}, req_in.byte2}; // RULE12 RULE23
      end
      EAU_M_MEM_IND: begin
        res_d.ea = {EAU_VEC_PAGE, req_in.byte2} & EAU_EVEN_MASK; // RULE14 RULE15
        fetch_d = 1'b1; // RULE14
      end
      default: begin
        res_d.ea = '0;
      end
    endcase
    // Small add and subtract carry their constant implicitly
    if (req_in.insn inside {EAU_I_ADD_SMALL, EAU_I_SUB_SMALL}) begin
      res_d.operand = req_in.small_two ? EAU_WORD_STEP : EAU_BYTE_STEP; // RULE11
    end
    if (grp == EAU_G_BIT) begin
      if (req_in.bit_reg) begin
        res_d.bit_num = bit_src[2:0]; // RULE18
      end else if (req_in.bit_b4) begin
        res_d.bit_num = req_in.ext_word[2:0]; // RULE11
      end else begin
        res_d.bit_num = req_in.byte2[2:0]; // RULE11
      end
    end
    if (req_in.insn == EAU_I_MOVE && req_in.word) begin
      res_d.ea = res_d.ea & EAU_EVEN_MASK; // RULE15
    end
    if (grp == EAU_G_BRANCH && req_in.mode == EAU_M_REG_INDIRECT) begin
      res_d.target = base; // RULE3
    end
    if (grp == EAU_G_BRANCH && req_in.mode == EAU_M_ABS16) begin
      res_d.target = req_in.ext_word; // RULE9
    end
    res_d.target = res_d.target & EAU_EVEN_MASK; // RULE15
    // Push and pop arrive as word moves on register 7 and need no path of their own
    res_d.stack = req_in.insn == EAU_I_MOVE && req_in.reg_idx == EAU_SP_IDX &&
      req_in.mode inside {EAU_M_PRE_DEC, EAU_M_POST_INC}; // RULE19
    // Calls push the return address, return pops it, both through register 7
    if (req_in.insn inside {EAU_I_BRANCH_SUB, EAU_I_JUMP_SUB}) begin
      res_d.stack_ea = (sp_val - EAU_WORD_STEP) & EAU_EVEN_MASK; // RULE21
      upd_en_d = 1'b1;
      upd_idx_d = EAU_SP_IDX;
      upd_val_d = sp_val - EAU_WORD_STEP; // RULE21
    end else if (req_in.insn == EAU_I_RETURN_SUB) begin
      res_d.stack_ea = sp_val & EAU_EVEN_MASK; // RULE21
      upd_en_d = 1'b1;
      upd_idx_d = EAU_SP_IDX;
      upd_val_d = sp_val + EAU_WORD_STEP; // RULE21
    end
  end

  // General registers; execution write-back has priority over base updates
  for (genvar i = 0; i < EAU_NUM_GPR; i++) begin : g_gpr
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        gpr_q[i] <= EAU_GPR_RST;
      end else if (gpr_wr_in && gpr_wr_idx_in == 3'(i)) begin
        gpr_q[i] <= gpr_wr_data_in;
      end else if (ok_take && upd_en_d && upd_idx_d == 3'(i)) begin
        gpr_q[i] <= upd_val_d; // RULE5 RULE6
      end
    end
  end

  // Sequencer: memory indirect waits for the target word
  // Busy is its own flop so the pin never glitches on a state decode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= EAU_ST_IDLE;
      busy_out <= 1'b0;
    end else begin
      case (state_q)
        EAU_ST_IDLE: begin
          if (ok_take && fetch_d) begin
            state_q <= EAU_ST_FETCH; // RULE14
            busy_out <= 1'b1;
          end
        end
        EAU_ST_FETCH: begin
          if (mem_ack_in) begin
            state_q <= EAU_ST_IDLE;
            busy_out <= 1'b0;
          end
        end
        default: begin
          state_q <= EAU_ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Memory read request stays up until acknowledged
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_rd_out <= 1'b0;
      mem_addr_out <= '0;
    end else if (ok_take && fetch_d) begin
      mem_rd_out <= 1'b1; // RULE14
      mem_addr_out <= res_d.ea;
    end else if (mem_ack_in) begin
      mem_rd_out <= 1'b0;
    end
  end

  // Result
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_valid_out <= 1'b0;
      res_err_out <= 1'b0;
      res_out <= '0;
    end else if (take) begin
      res_valid_out <= !(legal && fetch_d);
      res_err_out <= !legal;
      res_out <= res_d;
    end else if (state_q == EAU_ST_FETCH && mem_ack_in) begin
      res_valid_out <= 1'b1;
      res_err_out <= 1'b0;
      res_out.target <= mem_rdata_in & EAU_EVEN_MASK; // RULE14 RULE15
    end else begin
      res_valid_out <= 1'b0;
      res_err_out <= 1'b0;
    end
  end

  // Checking helpers: request, base, stack pointer and write strobe of the previous cycle
  eau_req_s chk_req_q;
  logic [15:0] chk_base_q;
  logic [15:0] chk_sp_q;
  logic chk_hit_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_req_q <= '0;
      chk_base_q <= '0;
      chk_sp_q <= '0;
      chk_hit_q <= 1'b0;
    end else begin
      chk_req_q <= req_in;
      chk_base_q <= base;
      chk_sp_q <= sp_val;
      chk_hit_q <= gpr_wr_in;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_abs8_page: assert property ( // RULE8
    ok_take && req_in.mode == EAU_M_ABS8 |=>
      res_valid_out && res_out.ea == {EAU_ABS8_PAGE, chk_req_q.byte2})
    else $error("short absolute address not in top page");

  a_postinc_reg: assert property ( // RULE5
    ok_take && req_in.mode == EAU_M_POST_INC && !gpr_wr_in |=>
      gpr_q[chk_req_q.reg_idx] == chk_base_q + (chk_req_q.word ? 16'h0002 : 16'h0001)
      && res_out.ea[15:1] == chk_base_q[15:1])
    else $error("post-increment step or address wrong");

  a_predec_ea: assert property ( // RULE6
    ok_take && req_in.mode == EAU_M_PRE_DEC && !gpr_wr_in |=>
      res_out.ea[15:1] == gpr_q[chk_req_q.reg_idx][15:1]
      && gpr_q[chk_req_q.reg_idx] == chk_base_q - (chk_req_q.word ? 16'h0002 : 16'h0001))
    else $error("pre-decrement address differs from kept register");

  a_rel_target: assert property ( // RULE12
    ok_take && req_in.mode == EAU_M_PC_REL |=>
      res_out.target == (({chk_req_q.pc[15:1], 1'b0}
      + {{8{chk_req_q.byte2[7]}}, chk_req_q.byte2}) & 16'hfffe))
    else $error("relative branch target wrong");

  a_memind_addr: assert property ( // RULE14
    mem_rd_out |-> mem_addr_out[15:8] == 8'h00 && !mem_addr_out[0])
    else $error("indirect fetch outside page zero");

  a_memind_done: assert property ( // RULE14
    mem_rd_out && mem_ack_in |=> res_valid_out && !mem_rd_out
      && res_out.target == ($past(mem_rdata_in) & 16'hfffe))
    else $error("indirect target not taken from memory word");

  a_mem_wait: assert property ( // RULE14
    mem_rd_out && !mem_ack_in |=> mem_rd_out && !res_valid_out && busy_out)
    else $error("indirect fetch dropped before acknowledge");

  a_word_even: assert property ( // RULE15
    res_valid_out && !res_err_out && res_out.word && res_out.insn == EAU_I_MOVE
      |-> !res_out.ea[0] && !res_out.target[0])
    else $error("word move address left odd");

  a_word_insn: assert property ( // RULE2
    res_valid_out && !res_err_out && res_out.word |->
      res_out.insn inside {EAU_I_MOVE, EAU_I_ADD, EAU_I_SUB, EAU_I_COMPARE,
      EAU_I_ADD_SMALL, EAU_I_SUB_SMALL, EAU_I_MUL_U, EAU_I_DIV_U})
    else $error("word operand on a byte-only instruction");

  a_disp_move: assert property ( // RULE4
    res_valid_out && !res_err_out && res_out.mode == EAU_M_DISP16 |->
      res_out.insn == EAU_I_MOVE)
    else $error("displacement mode outside moves");

  a_sp_call: assert property ( // RULE21
    ok_take && req_in.insn == EAU_I_BRANCH_SUB ##1 !chk_hit_q |->
      gpr_q[EAU_SP_IDX] == chk_sp_q - 16'h0002)
    else $error("subroutine call did not lower stack pointer by two");

  c_abs8: cover property (ok_take && req_in.mode == EAU_M_ABS8);
  c_push: cover property (ok_take && req_in.mode == EAU_M_PRE_DEC
    && req_in.reg_idx == EAU_SP_IDX && req_in.word);
  c_memind: cover property (mem_rd_out ##1 mem_ack_in);
  c_error: cover property (res_valid_out && res_err_out);

endmodule // eau_core

//--- hdl/eau_mode_check.sv
// Purpose: Decides whether an instruction may use the requested mode
// Assumes: Pure combinational, driven from the request of the same cycle
// Notes: Also reports the functional group of the instruction
`timescale 1ns/1ps
module eau_mode_check import eau_pkg::*; (
  // Request
  input wire eau_req_s req_in,
  // Verdict
  output logic legal_out,
  output eau_grp_e grp_out
);

  logic word_ok;
  logic imm_ok;
  logic stack;

  always_comb begin
    word_ok = req_in.insn inside {EAU_I_MOVE, EAU_I_ADD, EAU_I_SUB, EAU_I_COMPARE,
      EAU_I_ADD_SMALL, EAU_I_SUB_SMALL, EAU_I_MUL_U, EAU_I_DIV_U}; // RULE2
    imm_ok = req_in.insn inside {EAU_I_ADD, EAU_I_ADD_CARRY, EAU_I_SUB_CARRY,
      EAU_I_COMPARE, EAU_I_AND, EAU_I_OR, EAU_I_XOR} && !req_in.word; // RULE16
    stack = req_in.reg_idx == EAU_SP_IDX &&
      req_in.mode inside {EAU_M_PRE_DEC, EAU_M_POST_INC};
    legal_out = 1'b0;
    grp_out = EAU_G_SYSTEM;
    case (req_in.insn)
      EAU_I_MOVE: begin
        grp_out = EAU_G_TRANSFER;
        legal_out = !(req_in.mode inside {EAU_M_NONE, EAU_M_PC_REL, EAU_M_MEM_IND}); // RULE17
        if (req_in.mode == EAU_M_ABS8 && req_in.word) legal_out = 1'b0; // RULE9
        if (req_in.mode == EAU_M_IMM16 && !req_in.word) legal_out = 1'b0; // RULE10
        if (req_in.mode == EAU_M_POST_INC && req_in.store) legal_out = 1'b0; // RULE5
        if (req_in.mode == EAU_M_PRE_DEC && !req_in.store) legal_out = 1'b0; // RULE6
        if (stack && !req_in.word) legal_out = 1'b0; // RULE19
      end
      EAU_I_ADD, EAU_I_SUB, EAU_I_ADD_CARRY, EAU_I_SUB_CARRY, EAU_I_INC, EAU_I_DEC,
      EAU_I_DEC_ADJ_ADD, EAU_I_DEC_ADJ_SUB, EAU_I_MUL_U, EAU_I_DIV_U,
      EAU_I_COMPARE, EAU_I_NEG: begin
        grp_out = EAU_G_ARITH;
        legal_out = req_in.mode == EAU_M_REG_DIRECT ||
          (req_in.mode == EAU_M_IMM8 && imm_ok); // RULE16
      end
      EAU_I_ADD_SMALL, EAU_I_SUB_SMALL: begin
        grp_out = EAU_G_ARITH;
        legal_out = req_in.mode == EAU_M_REG_DIRECT && req_in.word; // RULE11
      end
      EAU_I_AND, EAU_I_OR, EAU_I_XOR, EAU_I_NOT: begin
        grp_out = EAU_G_LOGIC;
        legal_out = req_in.mode == EAU_M_REG_DIRECT ||
          (req_in.mode == EAU_M_IMM8 && imm_ok); // RULE16
      end
      EAU_I_SHL_ARITH, EAU_I_SHR_ARITH, EAU_I_SHL_LOG, EAU_I_SHR_LOG,
      EAU_I_ROT_L, EAU_I_ROT_R, EAU_I_ROT_CL, EAU_I_ROT_CR: begin
        grp_out = EAU_G_SHIFT;
        legal_out = req_in.mode == EAU_M_REG_DIRECT;
      end
      EAU_I_BIT_SET, EAU_I_BIT_CLR, EAU_I_BIT_INV, EAU_I_BIT_TEST: begin
        grp_out = EAU_G_BIT;
        legal_out = req_in.mode inside {EAU_M_REG_DIRECT, EAU_M_REG_INDIRECT,
          EAU_M_ABS8} && !req_in.word; // RULE18
      end
      EAU_I_BIT_AND, EAU_I_BIT_IAND, EAU_I_BIT_OR, EAU_I_BIT_IOR,
      EAU_I_BIT_XOR, EAU_I_BIT_IXOR, EAU_I_BIT_LOAD, EAU_I_BIT_ILOAD,
      EAU_I_BIT_STORE, EAU_I_BIT_ISTORE: begin
        grp_out = EAU_G_BIT;
        legal_out = req_in.mode inside {EAU_M_REG_DIRECT, EAU_M_REG_INDIRECT,
          EAU_M_ABS8} && !req_in.word && !req_in.bit_reg; // RULE18
      end
      EAU_I_BRANCH_COND, EAU_I_BRANCH_SUB: begin
        grp_out = EAU_G_BRANCH;
        legal_out = req_in.mode == EAU_M_PC_REL; // RULE12
      end
      EAU_I_JUMP, EAU_I_JUMP_SUB: begin
        grp_out = EAU_G_BRANCH;
        legal_out = req_in.mode inside {EAU_M_REG_INDIRECT, EAU_M_ABS16,
          EAU_M_MEM_IND}; // RULE9 RULE14
      end
      EAU_I_RETURN_SUB: begin
        grp_out = EAU_G_BRANCH;
        legal_out = req_in.mode == EAU_M_NONE;
      end
      EAU_I_CC_LOAD, EAU_I_CC_STORE, EAU_I_CC_AND, EAU_I_CC_OR, EAU_I_CC_XOR: begin
        legal_out = req_in.mode inside {EAU_M_REG_DIRECT, EAU_M_IMM8};
      end
      EAU_I_BLOCK_MOVE: begin
        grp_out = EAU_G_BLOCK;
        legal_out = req_in.mode == EAU_M_NONE;
      end
      default: begin
        legal_out = req_in.mode == EAU_M_NONE;
      end
    endcase
    if (req_in.word && !word_ok) legal_out = 1'b0; // RULE2
  end

endmodule // eau_mode_check

//--- hdl/eau_pkg.sv
// Purpose: Shared types and constants for the effective address unit
// Assumes: Opcode bits are already decoded into an instruction id and a mode
// Notes: Request and result travel as packed structs
package eau_pkg;

  localparam logic [7:0] EAU_ABS8_PAGE = 8'hff;
  localparam logic [7:0] EAU_VEC_PAGE = 8'h00;
  localparam logic [15:0] EAU_BYTE_STEP = 16'h0001;
  localparam logic [15:0] EAU_WORD_STEP = 16'h0002;
  localparam logic [15:0] EAU_EVEN_MASK = 16'hfffe;
  localparam logic [15:0] EAU_GPR_RST = 16'h0000;
  localparam logic [2:0] EAU_SP_IDX = 3'h7;
  localparam int unsigned EAU_NUM_GPR = 8;
  localparam int unsigned EAU_NUM_INSN = 55;

  // All 55 instructions, listed by functional group
  typedef enum logic [5:0] {
    EAU_I_MOVE,
    EAU_I_ADD, EAU_I_SUB, EAU_I_ADD_CARRY, EAU_I_SUB_CARRY, EAU_I_INC, EAU_I_DEC,
    EAU_I_ADD_SMALL, EAU_I_SUB_SMALL, EAU_I_DEC_ADJ_ADD, EAU_I_DEC_ADJ_SUB,
    EAU_I_MUL_U, EAU_I_DIV_U, EAU_I_COMPARE, EAU_I_NEG,
    EAU_I_AND, EAU_I_OR, EAU_I_XOR, EAU_I_NOT,
    EAU_I_SHL_ARITH, EAU_I_SHR_ARITH, EAU_I_SHL_LOG, EAU_I_SHR_LOG,
    EAU_I_ROT_L, EAU_I_ROT_R, EAU_I_ROT_CL, EAU_I_ROT_CR,
    EAU_I_BIT_SET, EAU_I_BIT_CLR, EAU_I_BIT_INV, EAU_I_BIT_TEST,
    EAU_I_BIT_AND, EAU_I_BIT_IAND, EAU_I_BIT_OR, EAU_I_BIT_IOR,
    EAU_I_BIT_XOR, EAU_I_BIT_IXOR, EAU_I_BIT_LOAD, EAU_I_BIT_ILOAD,
    EAU_I_BIT_STORE, EAU_I_BIT_ISTORE,
    EAU_I_BRANCH_COND, EAU_I_JUMP, EAU_I_BRANCH_SUB, EAU_I_JUMP_SUB, EAU_I_RETURN_SUB,
    EAU_I_RETURN_EXC, EAU_I_SLEEP, EAU_I_CC_LOAD, EAU_I_CC_STORE,
    EAU_I_CC_AND, EAU_I_CC_OR, EAU_I_CC_XOR, EAU_I_NOP,
    EAU_I_BLOCK_MOVE
  } eau_insn_e;

  typedef enum logic [3:0] {
    EAU_M_NONE, EAU_M_REG_DIRECT, EAU_M_REG_INDIRECT, EAU_M_DISP16,
    EAU_M_POST_INC, EAU_M_PRE_DEC, EAU_M_ABS8, EAU_M_ABS16,
    EAU_M_IMM8, EAU_M_IMM16, EAU_M_PC_REL, EAU_M_MEM_IND
  } eau_mode_e;

  typedef enum logic [2:0] {
    EAU_G_TRANSFER, EAU_G_ARITH, EAU_G_LOGIC, EAU_G_SHIFT,
    EAU_G_BIT, EAU_G_BRANCH, EAU_G_SYSTEM, EAU_G_BLOCK
  } eau_grp_e;

  typedef enum {EAU_ST_IDLE, EAU_ST_FETCH} eau_state_e;

  typedef struct packed {
    eau_insn_e insn;
    eau_mode_e mode;
    logic word;
    logic store;
    logic [2:0] reg_idx;
    logic reg_hi;
    logic bit_reg;
    logic [2:0] bit_ridx;
    logic bit_b4;
    logic small_two;
    logic [7:0] byte2;
    logic [15:0] ext_word;
    logic [15:0] pc;
  } eau_req_s;

  typedef struct packed {
    eau_insn_e insn;
    eau_mode_e mode;
    eau_grp_e grp;
    logic word;
    logic stack;
    logic [15:0] ea;
    logic [15:0] operand;
    logic [15:0] target;
    logic [15:0] stack_ea;
    logic [2:0] bit_num;
  } eau_res_s;

endpackage

//--- sim/eau_mem_model.sv
// Purpose: Data memory model answering the unit's read port
// Assumes: One read outstanding, answer after dly_in idle cycles
// Notes: Read word is {addr low byte, 8'h35} so a wrong address shows
`timescale 1ns/1ps
module eau_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Read port
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [3:0] dly_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      cnt_q <= 4'h0;
      rdata_out <= 16'h0000;
    end else if (ack_out) begin
      // Released bus shows the inverse, never the stale word
      ack_out <= 1'b0;
      cnt_q <= 4'h0;
      rdata_out <= ~rdata_out;
    end else if (mem_rd_in && cnt_q == dly_in) begin
      ack_out <= 1'b1;
      rdata_out <= {mem_addr_in[7:0], 8'h35};
    end else if (mem_rd_in) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // eau_mem_model

//--- sim/tb_eau_core.sv
// Purpose: Self-checking bench for the effective address unit
// Assumes: Requests one at a time, each waited out before the next
// Notes: Word move addresses in stimulus kept even, as software must
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_eau_core import eau_pkg::*;;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  eau_req_s req_in = '0;
  logic gpr_wr_in = 1'b0;
  logic [2:0] gpr_wr_idx_in = 3'h0;
  logic [15:0] gpr_wr_data_in = 16'h0000;
  logic mem_rd_out, mem_ack_in, busy_out, res_valid_out, res_err_out;
  logic [15:0] mem_addr_out, mem_rdata_in, sp_out;
  logic [3:0] dly = 4'h0;
  eau_res_s res_out;
  int fail_count = 0;
  int cmp_count = 0;
  int busy_n = 0;
  logic [15:0] rd_addr = 16'h0000;

  initial forever #4 clk_in = ~clk_in;

  eau_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .gpr_wr_in(gpr_wr_in), .gpr_wr_idx_in(gpr_wr_idx_in),
    .gpr_wr_data_in(gpr_wr_data_in), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
    .res_valid_out(res_valid_out), .res_err_out(res_err_out), .res_out(res_out),
    .sp_out(sp_out));

  eau_mem_model mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .dly_in(dly), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic eau_req_s mk(eau_insn_e i, eau_mode_e m, logic w, logic s,
    logic [2:0] r, logic [7:0] b2, logic [15:0] ext, logic [15:0] pc);
    eau_req_s q;
    q = '0;
    q.insn = i;
    q.mode = m;
    q.word = w;
    q.store = s;
    q.reg_idx = r;
    q.byte2 = b2;
    q.ext_word = ext;
    q.pc = pc;
    return q;
  endfunction

  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk_in);
    gpr_wr_in <= 1'b1;
    gpr_wr_idx_in <= idx;
    gpr_wr_data_in <= d;
    @(posedge clk_in);
    gpr_wr_in <= 1'b0;
  endtask

  // Issue one request, wait for its result, compare the error flag
  task automatic run(input eau_req_s r, input logic e);
    int n;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_in <= r;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
    busy_n = 0;
    rd_addr = 16'h0000;
    for (n = 0; n < 20 && res_valid_out !== 1'b1; n++) begin
      busy_n += (busy_out === 1'b1);
      if (mem_rd_out === 1'b1) rd_addr = mem_addr_out;
      @(posedge clk_in);
      #1;
    end
    if (n == 20) begin
      fail_count++;
      summarize();
    end
    `CHK("err", e, res_err_out)
  endtask

  task automatic t_abs8();
    run(mk(EAU_I_MOVE, EAU_M_ABS8, 0, 0, 0, 8'h12, 0, 0), 0);
    `CHK("abs8 ea", 16'hff12, res_out.ea)
  endtask

  task automatic t_post_inc();
    wr(3, 16'h0100);
    run(mk(EAU_I_MOVE, EAU_M_POST_INC, 1, 0, 3, 0, 0, 0), 0);
    `CHK("post ea", 16'h0100, res_out.ea)
    run(mk(EAU_I_MOVE, EAU_M_REG_INDIRECT, 1, 0, 3, 0, 0, 0), 0);
    `CHK("ind ea", 16'h0102, res_out.ea)
  endtask

  task automatic t_pre_dec();
    wr(2, 16'h0201);
    run(mk(EAU_I_MOVE, EAU_M_PRE_DEC, 0, 1, 2, 0, 0, 0), 0);
    `CHK("pre ea", 16'h0200, res_out.ea)
  endtask

  task automatic t_disp();
    wr(1, 16'hfff0);
    run(mk(EAU_I_MOVE, EAU_M_DISP16, 1, 0, 1, 0, 16'h0020, 0), 0);
    `CHK("disp ea", 16'h0010, res_out.ea)
  endtask

  task automatic t_branch();
    run(mk(EAU_I_BRANCH_COND, EAU_M_PC_REL, 0, 0, 0, 8'h80, 0, 16'h1000), 0);
    `CHK("rel tgt", 16'h0f80, res_out.target)
  endtask

  task automatic t_mem_ind(input logic [3:0] d);
    dly <= d;
    run(mk(EAU_I_JUMP, EAU_M_MEM_IND, 0, 0, 0, 8'h21, 0, 0), 0);
    `CHK("ind tgt", 16'h2034, res_out.target)
    `CHK("ind addr", 16'h0020, rd_addr)
    `CHK("ind busy", int'(d) + 2, busy_n)
    `CHK("rd drop", 1'b0, mem_rd_out)
  endtask

  task automatic t_reg_direct();
    eau_req_s q;
    wr(4, 16'hab12);
    q = mk(EAU_I_ADD, EAU_M_REG_DIRECT, 0, 0, 4, 0, 0, 0);
    q.reg_hi = 1'b1;
    run(q, 0);
    `CHK("rd hi", 16'h00ab, res_out.operand)
    run(mk(EAU_I_ADD, EAU_M_REG_DIRECT, 1, 0, 4, 0, 0, 0), 0);
    `CHK("rd word", 16'hab12, res_out.operand)
    q = mk(EAU_I_ADD_SMALL, EAU_M_REG_DIRECT, 1, 0, 4, 0, 0, 0);
    q.small_two = 1'b1;
    run(q, 0);
    `CHK("small", 16'h0002, res_out.operand)
  endtask

  // Needs register 4 from the direct scenario for the register bit number
  task automatic t_bit();
    eau_req_s q;
    q = mk(EAU_I_BIT_TEST, EAU_M_ABS8, 0, 0, 0, 8'h0d, 16'h0003, 0);
    run(q, 0);
    `CHK("bit b2", 3'h5, res_out.bit_num)
    `CHK("bit ea", 16'hff0d, res_out.ea)
    `CHK("bit grp", EAU_G_BIT, res_out.grp)
    q.bit_b4 = 1'b1;
    run(q, 0);
    `CHK("bit b4", 3'h3, res_out.bit_num)
    q.bit_reg = 1'b1;
    q.bit_ridx = 3'h4;
    run(q, 0);
    `CHK("bit reg", 3'h2, res_out.bit_num)
  endtask

  task automatic t_call();
    wr(7, 16'h0500);
    run(mk(EAU_I_BRANCH_SUB, EAU_M_PC_REL, 0, 0, 0, 8'h10, 0, 16'h2001), 0);
    `CHK("call tgt", 16'h2010, res_out.target)
    `CHK("call stk", 16'h04fe, res_out.stack_ea)
    `CHK("call sp", 16'h04fe, sp_out)
    run(mk(EAU_I_RETURN_SUB, EAU_M_NONE, 0, 0, 0, 0, 0, 0), 0);
    `CHK("ret stk", 16'h04fe, res_out.stack_ea)
    `CHK("ret sp", 16'h0500, sp_out)
  endtask

  task automatic t_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("rst sp", EAU_GPR_RST, sp_out)
    `CHK("rst busy", 1'b0, busy_out)
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_abs8();
  endtask

  task automatic t_stack();
    wr(7, 16'h0400);
    run(mk(EAU_I_MOVE, EAU_M_PRE_DEC, 1, 1, 7, 0, 0, 0), 0);
    `CHK("push ea", 16'h03fe, res_out.ea)
    `CHK("push sp", 16'h03fe, sp_out)
    `CHK("push stk", 1'b1, res_out.stack)
    run(mk(EAU_I_MOVE, EAU_M_POST_INC, 1, 0, 7, 0, 0, 0), 0);
    `CHK("pop sp", 16'h0400, sp_out)
  endtask

  task automatic t_imm_illegal();
    run(mk(EAU_I_MOVE, EAU_M_IMM16, 1, 0, 0, 0, 16'h1234, 0), 0);
    `CHK("imm16", 16'h1234, res_out.operand)
    run(mk(EAU_I_AND, EAU_M_DISP16, 0, 0, 0, 0, 0, 0), 1);
    run(mk(EAU_I_MOVE, EAU_M_PC_REL, 0, 0, 0, 0, 0, 0), 1);
    run(mk(EAU_I_ADD_CARRY, EAU_M_REG_DIRECT, 1, 0, 0, 0, 0, 0), 1);
    run(mk(EAU_I_BIT_SET, EAU_M_ABS16, 0, 0, 0, 0, 0, 0), 1);
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_abs8();
    t_post_inc();
    t_pre_dec();
    t_disp();
    t_branch();
    t_mem_ind(4'h0);
    t_mem_ind(4'h3);
    t_stack();
    t_reg_direct();
    t_bit();
    t_call();
    t_imm_illegal();
    t_reset();
    summarize();
  end
endmodule // tb_eau_core
